// [ois_store.sv]
// one-time-programmable info store with indirect access and lock state
// Summary of operation
// - 128 words of 32 bits, factory half and customer half of 64 each.
// - customer half: key, addresses, trim, lock, defaults, reserved, user data.
// - key words never read out once locked.
// - programming only clears bits; data is ANDed into the stored word.
// - unlock pattern in lock words enables programming of other customer words.
// - lock words all zero makes the whole store unmodifiable.
// - blank lock state denies read and write of key, address, trim.
// - closed lock state allows address and trim read only, key none.
// - lock state changes only when all four lock words agree.
// - access only via address, data and mode registers.
// - key word 0 holds bits 31:0, word 3 bits 127:96.
// - first address word holds the four high address bytes.
// - second address word: byte two bits 7:0, byte one bits 15:8.
// - trim code 0 lowest capacitance, 127 highest.
// - a zero bit in the defaults word marks a programmed register.
// - at power-up the stored addresses are reported to the host.
// - key is used for link cipher only when the host enables it.
`timescale 1ns/1ps
`default_nettype none
module ois_store (
   input  wire logic        clk,             // 100 MHz clock
   input  wire logic        resetn,          // async reset, active low
   input  wire logic [9:0]  addr_in,         // byte offset written to address register
   input  wire logic        addr_we,         // address register write strobe
   input  wire logic [31:0] data_in,         // data register write value
   input  wire logic        data_we,         // data register write strobe
   input  wire logic [1:0]  mode_in,         // mode register value, starts operation
   input  wire logic        mode_we,         // mode register write strobe
   input  wire logic        cipher_enable,   // host command enabling link cipher
   output logic [31:0]      data_out,        // data register read value
   output logic             busy,            // operation in progress
   output logic             denied,          // last access was refused
   output logic [127:0]     cipher_key_value,// key to the link cipher, zero when off
   output logic             cipher_active,   // link cipher running
   output logic [47:0]      addr_virtual_interface_zero,       // address for virtual interface zero
   output logic [47:0]      addr_virtual_interface_one,       // address for virtual interface one
   output logic             addr_report,     // one-cycle power-up address event
   output logic [6:0]       trim_code        // crystal trim setting
);
   // the array itself; contents survive reset as nonvolatile memory
   logic [31:0] mem [0:ois_pkg::WORDS-1];

   logic [ois_pkg::AW-1:0] addr_reg;
   logic [31:0]            wdata_reg;
   logic [31:0]            data_out_reg;
   logic                   denied_reg;
   logic [3:0]             cnt_reg;
   logic [2:0]             boot_reg;
   logic [47:0]            virtual_interface_zero_reg;
   logic [47:0]            virtual_interface_one_reg;
   logic                   report_reg;
   logic [6:0]             trim_reg;
   logic [127:0]           key_out_reg;
   logic                   cact_reg;
   logic                   busy_reg;
   ois_pkg::ois_state_t    state_reg;
   ois_pkg::ois_state_t    state_next;

   // word index from byte offset; customer offsets are above the factory half
   function automatic logic [6:0] widx(input logic [9:0] off);
      widx = off[8:2];
   endfunction : widx

   function automatic ois_pkg::ois_grp_t grp_of(input logic [6:0] w);
      if (w >= widx(ois_pkg::OFF_KEY) && w < widx(ois_pkg::OFF_ADDR))
         grp_of = ois_pkg::GRP_KEY;
      else if (w >= widx(ois_pkg::OFF_ADDR) && w < widx(ois_pkg::OFF_TRIM))
         grp_of = ois_pkg::GRP_ADDR;
      else if (w == widx(ois_pkg::OFF_TRIM))
         grp_of = ois_pkg::GRP_TRIM;
      else
         grp_of = ois_pkg::GRP_OTHER;
   endfunction : grp_of

   logic is_open;
   logic is_closed;
   logic is_blank;
   ois_lock_decode u_lock (
      .lock0     (mem[widx(ois_pkg::OFF_LOCK)]),
      .lock1     (mem[widx(ois_pkg::OFF_LOCK) + 7'h01]),
      .lock2     (mem[widx(ois_pkg::OFF_LOCK) + 7'h02]),
      .lock3     (mem[widx(ois_pkg::OFF_LOCK) + 7'h03]),
      .is_open   (is_open),
      .is_closed (is_closed),
      .is_blank  (is_blank)
   );

   // lock state held until all four words agree again
   logic lk_agree;
   logic lk_open;
   logic lk_closed;
   logic lk_blank;
   logic lk_open_reg;
   logic lk_closed_reg;

   // a mixed set of lock words keeps the previous state
   assign lk_agree  = is_open || is_closed || is_blank;
   assign lk_open   = lk_agree ? is_open : lk_open_reg;
   assign lk_closed = lk_agree ? is_closed : lk_closed_reg;
   assign lk_blank  = !lk_open && !lk_closed;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lk_open_reg   <= 1'b0;
         lk_closed_reg <= 1'b0;
      end else if (lk_agree) begin
         lk_open_reg   <= is_open;
         lk_closed_reg <= is_closed;
      end
   end

   ois_pkg::ois_grp_t grp;
   logic              is_cust;
   logic              is_lockw;
   logic              rd_ok;
   logic              wr_ok;
   logic              start_rd;
   logic              start_wr;
   assign grp      = grp_of(addr_reg);
   assign is_cust  = addr_reg >= ois_pkg::CUST_BASE;
   assign is_lockw = addr_reg >= widx(ois_pkg::OFF_LOCK) && addr_reg < widx(ois_pkg::OFF_KEY);
   assign rd_ok = (grp == ois_pkg::GRP_OTHER) ? 1'b1 :
                  (grp == ois_pkg::GRP_KEY)   ? lk_open : (lk_open || lk_closed);
   // write grant: factory words never, lock words until closed, other customer words only when open
   assign wr_ok = !is_cust ? 1'b0 : is_lockw ? !lk_closed : lk_open;
   assign start_rd = mode_we && (mode_in == ois_pkg::MODE_READ) && (state_reg == ois_pkg::OIS_IDLE);
   assign start_wr = mode_we && (mode_in == ois_pkg::MODE_PROG) && (state_reg == ois_pkg::OIS_IDLE);

   always_comb begin
      case (state_reg)
         ois_pkg::OIS_IDLE: state_next = start_rd ? ois_pkg::OIS_READ :
                                         (start_wr && wr_ok) ? ois_pkg::OIS_PROG : ois_pkg::OIS_IDLE;
         ois_pkg::OIS_READ: state_next = ois_pkg::OIS_IDLE;
         ois_pkg::OIS_PROG: state_next = (cnt_reg == 4'h1) ? ois_pkg::OIS_IDLE : ois_pkg::OIS_PROG;
         default:           state_next = ois_pkg::OIS_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         addr_reg  <= 7'h00;
         wdata_reg <= ois_pkg::ERASED_WORD;
      end else if (state_reg == ois_pkg::OIS_IDLE) begin
         if (addr_we)
            addr_reg <= widx(addr_in);
         if (data_we)
            wdata_reg <= data_in;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ois_pkg::OIS_IDLE;
         cnt_reg   <= 4'h0;
      end else begin
         state_reg <= state_next;
         if (start_wr && wr_ok && state_reg == ois_pkg::OIS_IDLE)
            cnt_reg <= ois_pkg::PROG_CYC;
         else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
      end
   end

   // busy registered so the output comes straight from a flip-flop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         busy_reg <= 1'b0;
      else
         busy_reg <= state_next != ois_pkg::OIS_IDLE;
   end

   always @(posedge clk) begin
      if (state_reg == ois_pkg::OIS_PROG && cnt_reg == 4'h1)
         mem[addr_reg] <= mem[addr_reg] & wdata_reg;
   end

   // refused requests flag, refused reads load zero into the data register, store untouched
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         data_out_reg <= 32'h00000000;
         denied_reg   <= 1'b0;
      end else if (start_rd) begin
         data_out_reg <= rd_ok ? mem[addr_reg] : 32'h00000000;
         denied_reg   <= !rd_ok;
      end else if (start_wr) begin
         denied_reg <= !wr_ok;
      end
   end

   // power-up sequence: fetch addresses and trim, then report once
   logic [6:0] a0;
   assign a0 = widx(ois_pkg::OFF_ADDR);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         boot_reg   <= 3'h0;
         virtual_interface_zero_reg   <= 48'h000000000000;
         virtual_interface_one_reg   <= 48'h000000000000;
         trim_reg   <= 7'h00;
         report_reg <= 1'b0;
      end else begin
         report_reg <= 1'b0;
         if (boot_reg != 3'h4)
            boot_reg <= boot_reg + 3'h1;
         if (boot_reg == 3'h3) begin
            // high four bytes then byte one, byte two
            virtual_interface_zero_reg   <= {mem[a0], mem[a0 + 7'h01][15:8], mem[a0 + 7'h01][7:0]};
            virtual_interface_one_reg   <= {mem[a0 + 7'h02], mem[a0 + 7'h03][15:8], mem[a0 + 7'h03][7:0]};
            // trim taken only when marked programmed in defaults word
            trim_reg   <= mem[widx(ois_pkg::OFF_DEFAULTS)][0] ? 7'h00 :
                          mem[widx(ois_pkg::OFF_TRIM)][ois_pkg::TRIM_W-1:0];
            report_reg <= 1'b1;
         end
      end
   end

   // key assembled little word first, driven only when enabled
   logic [6:0] k0;
   assign k0 = widx(ois_pkg::OFF_KEY);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         key_out_reg <= 128'h0;
         cact_reg    <= 1'b0;
      end else begin
         cact_reg    <= cipher_enable;
         key_out_reg <= cipher_enable ? {mem[k0 + 7'h03], mem[k0 + 7'h02], mem[k0 + 7'h01], mem[k0]} : 128'h0;
      end
   end

   // outputs straight from their registers
   assign data_out         = data_out_reg;
   assign busy             = busy_reg;
   assign denied           = denied_reg;
   assign cipher_key_value = key_out_reg;
   assign cipher_active    = cact_reg;
   assign addr_virtual_interface_zero        = virtual_interface_zero_reg;
   assign addr_virtual_interface_one        = virtual_interface_one_reg;
   assign addr_report      = report_reg;
   assign trim_code        = trim_reg;

   // checks on grants, program timing and the power-up report
   // helper: cycles spent in the program state, for the length check
   logic [3:0] prog_run_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         prog_run_reg <= 4'h0;
      else if (state_reg == ois_pkg::OIS_PROG)
         prog_run_reg <= prog_run_reg + 4'h1;
      else
         prog_run_reg <= 4'h0;
   end

   // an accepted program request at an idle store
   sequence s_prog_start;
      (state_reg == ois_pkg::OIS_IDLE) && start_wr && wr_ok;
   endsequence
   // a read request at an idle store
   sequence s_read_start;
      start_rd;
   endsequence
   a_prog_enters: assert property (@(posedge clk) disable iff (!resetn)
      s_prog_start |=> state_reg == ois_pkg::OIS_PROG)
      else $error("program did not start");
   a_closed_no_write: assert property (@(posedge clk) disable iff (!resetn)
      lk_closed |-> state_next != ois_pkg::OIS_PROG || state_reg == ois_pkg::OIS_PROG)
      else $error("write started while closed");
   a_key_hidden: assert property (@(posedge clk) disable iff (!resetn)
      (start_rd && grp == ois_pkg::GRP_KEY && !lk_open) |=> data_out == 32'h0 && denied)
      else $error("key readable while not open");
   a_blank_deny: assert property (@(posedge clk) disable iff (!resetn)
      (start_rd && grp != ois_pkg::GRP_OTHER && lk_blank) |=> denied)
      else $error("blank state read not denied");
   a_lock_held: assert property (@(posedge clk) disable iff (!resetn)
      !lk_agree |-> $stable(lk_open) && $stable(lk_closed))
      else $error("lock state changed while words disagree");
   a_addr_readable: assert property (@(posedge clk) disable iff (!resetn)
      (start_rd && grp == ois_pkg::GRP_ADDR && lk_closed) |=> !denied)
      else $error("address read refused while closed");
   a_read_short: assert property (@(posedge clk) disable iff (!resetn)
      s_read_start |=> busy ##1 !busy)
      else $error("read length wrong");
   a_refused_prog: assert property (@(posedge clk) disable iff (!resetn)
      (start_wr && !wr_ok) |=> state_reg == ois_pkg::OIS_IDLE && denied)
      else $error("refused program proceeded");
   a_prog_clears: assert property (@(posedge clk) disable iff (!resetn)
      (state_reg == ois_pkg::OIS_PROG && cnt_reg == 4'h1) |=> (mem[$past(addr_reg)] & ~$past(mem[addr_reg])) == 32'h0)
      else $error("program set a bit");
   a_prog_length: assert property (@(posedge clk) disable iff (!resetn)
      $fell(state_reg == ois_pkg::OIS_PROG) |-> prog_run_reg == ois_pkg::PROG_CYC && !busy)
      else $error("program length wrong");
   a_report_once: assert property (@(posedge clk) disable iff (!resetn)
      addr_report |=> !addr_report [*4])
      else $error("address report repeated");
   a_cipher_off: assert property (@(posedge clk) disable iff (!resetn)
      !cipher_enable |=> cipher_key_value == 128'h0)
      else $error("key driven while cipher off");
endmodule : ois_store
`default_nettype wire

// [ois_pkg.sv]
// shared constants for the one-time-programmable info store
package ois_pkg;
   localparam int          WORDS          = 128;
   localparam int          AW             = 7;
   localparam logic [6:0]  CUST_BASE      = 7'h40;
   localparam logic [9:0]  OFF_PART       = 10'h0C0;
   localparam logic [9:0]  OFF_VARIANT    = 10'h0C4;
   localparam logic [9:0]  OFF_UUID       = 10'h0D0;
   localparam logic [9:0]  OFF_LOCK       = 10'h100;
   localparam logic [9:0]  OFF_KEY        = 10'h110;
   localparam logic [9:0]  OFF_ADDR       = 10'h120;
   localparam logic [9:0]  OFF_TRIM       = 10'h130;
   localparam logic [9:0]  OFF_DEFAULTS   = 10'h154;
   localparam logic [9:0]  OFF_USER       = 10'h198;
   localparam logic [31:0] LOCK_BLANK     = 32'hFFFFFFFF;
   localparam logic [31:0] LOCK_OPEN      = 32'h50FA50FA;
   localparam logic [31:0] LOCK_CLOSED    = 32'h00000000;
   localparam logic [31:0] ERASED_WORD    = 32'hFFFFFFFF;
   localparam int          TRIM_W         = 7;
   localparam int          PROG_NS        = 100;
   localparam int          CLK_NS         = 10;
   localparam logic [3:0]  PROG_CYC       = 4'((PROG_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [1:0]  MODE_IDLE      = 2'h0;
   localparam logic [1:0]  MODE_READ      = 2'h1;
   localparam logic [1:0]  MODE_PROG      = 2'h2;
   typedef enum logic [2:0] {
      OIS_IDLE = 3'b001,
      OIS_READ = 3'b010,
      OIS_PROG = 3'b100
   } ois_state_t;
   typedef enum logic [1:0] {
      GRP_OTHER = 2'h0,
      GRP_KEY   = 2'h1,
      GRP_ADDR  = 2'h2,
      GRP_TRIM  = 2'h3
   } ois_grp_t;
endpackage : ois_pkg

// [ois_lock_decode.sv]
// decodes the four lock words into the current lock state
`timescale 1ns/1ps
`default_nettype none
module ois_lock_decode (
   input  wire logic [31:0] lock0,       // lock word 0
   input  wire logic [31:0] lock1,       // lock word 1
   input  wire logic [31:0] lock2,       // lock word 2
   input  wire logic [31:0] lock3,       // lock word 3
   output logic             is_open,     // all four hold the unlock pattern
   output logic             is_closed,   // all four hold zero
   output logic             is_blank     // all four unprogrammed
);
   logic same;
   assign same      = (lock0 == lock1) && (lock1 == lock2) && (lock2 == lock3);
   assign is_open   = same && (lock0 == ois_pkg::LOCK_OPEN);
   assign is_closed = same && (lock0 == ois_pkg::LOCK_CLOSED);
   assign is_blank  = same && (lock0 == ois_pkg::LOCK_BLANK);
endmodule : ois_lock_decode
`default_nettype wire

// [tb_otp_info_store_protection.sv]
// self-checking bench for the info store lock and indirect access
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_otp_info_store_protection;
   logic         clk, resetn, addr_we, data_we, mode_we, cipher_enable;
   logic [9:0]   addr_in;
   logic [31:0]  data_in, data_out;
   logic [1:0]   mode_in;
   logic         busy, denied, cipher_active, addr_report;
   logic [127:0] cipher_key_value;
   logic [47:0]  addr_virtual_interface_zero, addr_virtual_interface_one;
   logic [6:0]   trim_code;
   int           n_errors, total_checks, bc;
   localparam logic [1:0] RD = ois_pkg::MODE_READ;
   localparam logic [1:0] PG = ois_pkg::MODE_PROG;

   ois_store uut (.clk(clk), .resetn(resetn), .addr_in(addr_in), .addr_we(addr_we), .data_in(data_in),
      .data_we(data_we), .mode_in(mode_in), .mode_we(mode_we), .cipher_enable(cipher_enable),
      .data_out(data_out), .busy(busy), .denied(denied), .cipher_key_value(cipher_key_value),
      .cipher_active(cipher_active), .addr_virtual_interface_zero(addr_virtual_interface_zero), .addr_virtual_interface_one(addr_virtual_interface_one),
      .addr_report(addr_report), .trim_code(trim_code));

   always #5 clk = ~clk;

   task end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   // address, data, mode in order, then watch a fixed window for busy
   task op(input logic [9:0] a, input logic [31:0] d, input logic [1:0] m,
           input logic [31:0] ed, input logic eden, input int ebc);
      @(negedge clk);
      addr_in = a;
      addr_we = 1'b1;
      @(negedge clk);
      addr_we = 1'b0;
      data_in = d;
      data_we = 1'b1;
      @(negedge clk);
      data_we = 1'b0;
      mode_in = m;
      mode_we = 1'b1;
      @(negedge clk);
      mode_we = 1'b0;
      bc = 0;
      repeat (16) begin
         if (busy === 1'b1) bc++;
         @(negedge clk);
      end
      `CHK(denied, eden)
      if (m == RD) `CHK(data_out, ed)
      if (m == PG) `CHK(32'(bc), 32'(ebc))
   endtask : op

   task do_reset;
      @(negedge clk);
      resetn = 1'b0;
      repeat (5) @(negedge clk);
      `CHK(busy, 1'b0)
      resetn = 1'b1;
      bc = 0;
      repeat (10) begin
         @(negedge clk);
         if (addr_report === 1'b1) bc++;
      end
   endtask : do_reset

   initial begin
      #100us;
      n_errors++;
      end_of_test();
   end

   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      addr_we = 1'b0;
      data_we = 1'b0;
      mode_we = 1'b0;
      cipher_enable = 1'b0;
      addr_in = 10'h000;
      data_in = 32'h00000000;
      mode_in = 2'h0;
      n_errors = 0;
      total_checks = 0;
      for (int i = 0; i < ois_pkg::WORDS; i++) uut.mem[i] = ois_pkg::ERASED_WORD;
      do_reset();
      op(10'h110, 32'h0, RD, 32'h0, 1'b1, 0);
      op(10'h120, 32'h0, RD, 32'h0, 1'b1, 0);
      op(10'h130, 32'h0, RD, 32'h0, 1'b1, 0);
      op(10'h130, 32'h0, PG, 32'h0, 1'b1, 0);
      op(10'h198, 32'h0, PG, 32'h0, 1'b1, 0);
      op(10'h0C0, 32'h0, PG, 32'h0, 1'b1, 0);
      op(10'h104, 32'h0, RD, 32'hFFFFFFFF, 1'b0, 0);
      for (int i = 0; i < 3; i++) op(10'h100 + 10'(4 * i), 32'h50FA50FA, PG, 32'h0, 1'b0, 10);
      op(10'h110, 32'h0, PG, 32'h0, 1'b1, 0);
      op(10'h10C, 32'h50FA50FA, PG, 32'h0, 1'b0, 10);
      for (int i = 0; i < 4; i++) op(10'h110 + 10'(4 * i), 32'hA5A50000 | i, PG, 32'h0, 1'b0, 10);
      op(10'h110, 32'hFFFF00FF, PG, 32'h0, 1'b0, 10);
      op(10'h110, 32'hFFFFFFFF, PG, 32'h0, 1'b0, 10);
      op(10'h110, 32'h0, RD, 32'hA5A50000, 1'b0, 0);
      op(10'h11C, 32'h0, RD, 32'hA5A50003, 1'b0, 0);
      op(10'h120, 32'h01234567, PG, 32'h0, 1'b0, 10);
      op(10'h124, 32'hFFFF89AB, PG, 32'h0, 1'b0, 10);
      op(10'h128, 32'hFEDCBA98, PG, 32'h0, 1'b0, 10);
      op(10'h12C, 32'h00007654, PG, 32'h0, 1'b0, 10);
      op(10'h130, 32'h0000007F, PG, 32'h0, 1'b0, 10);
      op(10'h154, 32'hFFFFFFFE, PG, 32'h0, 1'b0, 10);
      op(10'h198, 32'h12345678, PG, 32'h0, 1'b0, 10);
      cipher_enable = 1'b1;
      repeat (3) @(negedge clk);
      `CHK(cipher_active, 1'b1)
      `CHK(cipher_key_value, {32'hA5A50003, 32'hA5A50002, 32'hA5A50001, 32'hA5A50000})
      cipher_enable = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(cipher_key_value, 128'h0)
      `CHK(cipher_active, 1'b0)
      op(10'h100, 32'h0, PG, 32'h0, 1'b0, 10);
      op(10'h110, 32'h0, RD, 32'hA5A50000, 1'b0, 0);
      for (int i = 1; i < 4; i++) op(10'h100 + 10'(4 * i), 32'h0, PG, 32'h0, 1'b0, 10);
      op(10'h110, 32'h0, RD, 32'h0, 1'b1, 0);
      op(10'h120, 32'h0, RD, 32'h01234567, 1'b0, 0);
      op(10'h130, 32'h0, RD, 32'h0000007F, 1'b0, 0);
      op(10'h120, 32'h0, PG, 32'h0, 1'b1, 0);
      op(10'h198, 32'h0, PG, 32'h0, 1'b1, 0);
      op(10'h100, 32'h0, PG, 32'h0, 1'b1, 0);
      op(10'h198, 32'h0, RD, 32'h12345678, 1'b0, 0);
      do_reset();
      `CHK(32'(bc), 32'h1)
      `CHK(addr_virtual_interface_zero, {32'h01234567, 8'h89, 8'hAB})
      `CHK(addr_virtual_interface_one, {32'hFEDCBA98, 8'h76, 8'h54})
      `CHK(trim_code, 7'h7F)
      end_of_test();
   end
endmodule : tb_otp_info_store_protection
`default_nettype wire
